/* File: verilog/ardw_dma_writer.sv */
// Purpose: instruction driven writer of converter results into data RAM
// Assumes: synchronous inputs, 10 MHz clk_i, sync active-high reset
// Notes: registers reached over classic Wishbone, 32-bit data
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ardw_cfg.svh"

// Summary of operation
// - each data instruction writes 2 or 4 bytes; end codes write none
// - 00000000b ends; 10000000b ends and leaves conversion continuous
// - x0010000b writes A high:low; x0100000b writes B high:low
// - x0110000b writes A pair then B pair, four bytes
// - x10x0000b writes the differential result from the A position
// - x11x0000b writes differential pair then B pair
// - instruction words share the instr_data_reg bit layout
// - on-chip writes happen only while the core leaves that RAM idle
// - halt 0 gives off-chip RAM to the engine, 1 to the core
// - with halt 0 core off-chip accesses never reach the RAM
// - off-chip writes wait until halt is 0 again
// - a result arriving before the previous is taken flags overflow
// - write_ptr_high and write_ptr_low hold the 16-bit write address
// - converters not used by the list stay under processor control
module ardw_dma_writer (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // converters
   input wire logic [15:0] conv_a_result_i,
   input wire logic conv_a_done_i,
   input wire logic [15:0] conv_b_result_i,
   input wire logic conv_b_done_i,
   output logic conv_a_dma_own_o,
   output logic conv_b_dma_own_o,
   output logic diff_mode_o,
   output logic continuous_o,
   // on-chip data RAM
   input wire logic core_ram_busy_i,
   output ardw_pkg::ardw_mem_wr_type onchip_wr_o,
   // off-chip data RAM
   input wire ardw_pkg::ardw_mem_wr_type core_xmem_i,
   output ardw_pkg::ardw_mem_wr_type offchip_wr_o,
   output logic core_xmem_grant_o,
   output logic offchip_busy_o,
   // interrupt
   output logic irq_o
);
   logic [7:0] instr_list [`ARDW_LIST_DEPTH];
   logic [`ARDW_LIST_AW-1:0] instr_idx;
   logic [`ARDW_LIST_AW-1:0] pc;
   logic cfg_en;
   logic cfg_offchip;
   logic offchip_halt;
   logic [7:0] write_ptr_high;
   logic [7:0] write_ptr_low;
   logic [1:0] stat;
   logic [1:0] mask;
   logic [31:0] rd_data;
   logic acc;
   logic wr;
   logic wr_lo;
   ardw_pkg::ardw_state_type state;
   ardw_pkg::ardw_instr_type cur;
   ardw_pkg::ardw_instr_type dec;
   logic [31:0] wbuf;
   logic [1:0] bytes_left;
   logic [15:0] hold [2];
   logic [1:0] valid;
   logic [1:0] take;
   logic [1:0] ovf;
   logic [1:0] done_in;
   logic [15:0] res_in [2];
   logic ready;
   logic issue;
   logic done_ev;
   logic [1:0] next_stat;

   function automatic ardw_pkg::ardw_instr_type decode(input logic [7:0] w);
      ardw_pkg::ardw_instr_type d;
      d = '0;
      if (w[6:0] == 7'h00) begin
         d.is_end = 1'b1;
         d.cont = w[7];
      end else if (w[3:0] == 4'h0) begin
         // same bit layout as instr_data_reg
         d.diff = w[6];
         d.use_a = w[6] | w[4];
         d.use_b = w[5];
      end else begin
         d.is_end = 1'b1;
      end
      return d;
   endfunction

   // bus decode
   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = acc & wb_we_i;
   assign wr_lo = wr & wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr_i)
         `ARDW_OFS_CFG: begin
            rd_data[`ARDW_CFG_EN] = cfg_en;
            rd_data[`ARDW_CFG_OFFCHIP] = cfg_offchip;
            rd_data[`ARDW_CFG_HALT] = offchip_halt;
            rd_data[`ARDW_CFG_BUSY] = offchip_busy_o;
            rd_data[`ARDW_CFG_CONT] = continuous_o;
         end
         `ARDW_OFS_INSTR_DATA: rd_data[7:0] = instr_list[instr_idx];
         `ARDW_OFS_INSTR_IDX: rd_data[`ARDW_LIST_AW-1:0] = instr_idx;
         `ARDW_OFS_PTR_LOW: rd_data[7:0] = write_ptr_low;
         `ARDW_OFS_PTR_HIGH: rd_data[7:0] = write_ptr_high;
         `ARDW_OFS_STATUS: rd_data[1:0] = stat;
         `ARDW_OFS_MASK: rd_data[1:0] = mask;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (acc & ~wb_we_i) begin
         wb_dat_o <= rd_data;
      end
   end

   // configuration; a finished list clears the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_en <= 1'b0;
         cfg_offchip <= 1'b0;
         offchip_halt <= `ARDW_RST_HALT;
         mask <= `ARDW_RST_MASK;
      end else begin
         if (wr_lo && wb_adr_i == `ARDW_OFS_CFG) begin
            cfg_en <= wb_dat_i[`ARDW_CFG_EN];
            cfg_offchip <= wb_dat_i[`ARDW_CFG_OFFCHIP];
            offchip_halt <= wb_dat_i[`ARDW_CFG_HALT];
         end else if (done_ev) begin
            cfg_en <= 1'b0;
         end
         if (wr_lo && wb_adr_i == `ARDW_OFS_MASK) begin
            mask <= wb_dat_i[1:0];
         end
      end
   end

   // instruction list loading, index steps after each data write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_idx <= '0;
      end else if (wr_lo && wb_adr_i == `ARDW_OFS_INSTR_IDX) begin
         instr_idx <= wb_dat_i[`ARDW_LIST_AW-1:0];
      end else if (wr_lo && wb_adr_i == `ARDW_OFS_INSTR_DATA) begin
         instr_idx <= instr_idx + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_lo && wb_adr_i == `ARDW_OFS_INSTR_DATA) begin
         instr_list[instr_idx] <= wb_dat_i[7:0];
      end
   end

   // converter result holding, one slot per converter
   assign res_in[0] = conv_a_result_i;
   assign res_in[1] = conv_b_result_i;
   assign done_in = {conv_b_done_i, conv_a_done_i};
   assign dec = decode(instr_list[pc]);
   assign ready = (~cur.use_a | valid[0]) & (~cur.use_b | valid[1]);
   assign take = (state == ardw_pkg::ST_WAIT && ready) ?
      {cur.use_b, cur.use_a} : 2'b00;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_conv
         // an unconsumed word blocks the new one
         assign ovf[gi] = done_in[gi] & valid[gi] & ~take[gi];
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               valid[gi] <= 1'b0;
               hold[gi] <= 16'h0000;
            end else if (done_in[gi] && !ovf[gi]) begin
               valid[gi] <= 1'b1;
               hold[gi] <= res_in[gi];
            end else if (take[gi]) begin
               valid[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // engine sequencing
   assign issue = state == ardw_pkg::ST_WRITE &&
      (cfg_offchip ? ~offchip_halt : ~core_ram_busy_i);
   assign done_ev = state == ardw_pkg::ST_FETCH && dec.is_end;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ardw_pkg::ST_IDLE;
         pc <= '0;
         cur <= '0;
         wbuf <= 32'h0000_0000;
         bytes_left <= 2'h0;
         continuous_o <= 1'b0;
      end else if (!cfg_en) begin
         state <= ardw_pkg::ST_IDLE;
         pc <= '0;
         cur <= '0;
      end else begin
         unique case (state)
            ardw_pkg::ST_IDLE: begin
               state <= ardw_pkg::ST_FETCH;
               pc <= '0;
               continuous_o <= 1'b0;
            end
            ardw_pkg::ST_FETCH: begin
               pc <= pc + 1'b1;
               cur <= dec;
               if (dec.is_end) begin
                  continuous_o <= dec.cont;
                  state <= ardw_pkg::ST_IDLE;
               end else begin
                  state <= ardw_pkg::ST_WAIT;
               end
            end
            ardw_pkg::ST_WAIT: begin
               if (ready) begin
                  // first pair: A or differential, then B
                  wbuf <= cur.use_a ? {hold[0], hold[1]} :
                     {hold[1], 16'h0000};
                  bytes_left <= (cur.use_a & cur.use_b) ? 2'h3 : 2'h1;
                  state <= ardw_pkg::ST_WRITE;
               end
            end
            ardw_pkg::ST_WRITE: begin
               if (issue) begin
                  wbuf <= {wbuf[23:0], 8'h00};
                  bytes_left <= bytes_left - 1'b1;
                  if (bytes_left == 2'h0) begin
                     state <= ardw_pkg::ST_FETCH;
                  end
               end
            end
         endcase
      end
   end

   // write pointer, software load wins over stepping
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {write_ptr_high, write_ptr_low} <= `ARDW_RST_PTR;
      end else if (wr_lo && wb_adr_i == `ARDW_OFS_PTR_LOW) begin
         write_ptr_low <= wb_dat_i[7:0];
      end else if (wr_lo && wb_adr_i == `ARDW_OFS_PTR_HIGH) begin
         write_ptr_high <= wb_dat_i[7:0];
      end else if (issue) begin
         {write_ptr_high, write_ptr_low} <=
            {write_ptr_high, write_ptr_low} + 16'h0001;
      end
   end

   // on-chip RAM port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         onchip_wr_o <= '0;
      end else begin
         onchip_wr_o.we <= issue & ~cfg_offchip;
         onchip_wr_o.addr <= {write_ptr_high, write_ptr_low};
         onchip_wr_o.data <= wbuf[31:24];
      end
   end

   // off-chip RAM port, owned by the engine while halt is 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         offchip_wr_o <= '0;
         offchip_busy_o <= 1'b0;
         core_xmem_grant_o <= 1'b0;
      end else begin
         core_xmem_grant_o <= offchip_halt;
         offchip_busy_o <= issue & cfg_offchip;
         if (offchip_halt) begin
            offchip_wr_o <= core_xmem_i;
         end else begin
            // core accesses dropped here
            offchip_wr_o.we <= issue & cfg_offchip;
            offchip_wr_o.addr <= {write_ptr_high, write_ptr_low};
            offchip_wr_o.data <= wbuf[31:24];
         end
      end
   end

   // converter ownership
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_a_dma_own_o <= 1'b0;
         conv_b_dma_own_o <= 1'b0;
         diff_mode_o <= 1'b0;
      end else begin
         conv_a_dma_own_o <= cfg_en & cur.use_a;
         conv_b_dma_own_o <= cfg_en & cur.use_b;
         diff_mode_o <= cfg_en & cur.diff;
      end
   end

   // sticky status, write one to clear, set wins
   assign next_stat = (stat & ~((wr_lo && wb_adr_i == `ARDW_OFS_STATUS) ?
      wb_dat_i[1:0] : 2'b00)) | {|ovf, done_ev};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat <= 2'b00;
         irq_o <= 1'b0;
      end else begin
         stat <= next_stat;
         irq_o <= |(next_stat & mask);
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_END_NO_WRITE:
      assert property (done_ev |=> !onchip_wr_o.we && !offchip_busy_o)
      else $error("end instruction produced a write");
   AST_BYTE_COUNT:
      assert property ((state == ardw_pkg::ST_WAIT && ready) |=>
         bytes_left == ((cur.use_a & cur.use_b) ? 2'h3 : 2'h1))
      else $error("byte count is not 2 or 4");
   AST_FIRST_PAIR:
      assert property ((state == ardw_pkg::ST_WAIT && ready && cur.use_a)
         |=> wbuf[31:16] == $past(hold[0]))
      else $error("first pair is not the A result");
   AST_ONCHIP_YIELD:
      assert property (onchip_wr_o.we |-> !$past(core_ram_busy_i))
      else $error("on-chip write while core used the RAM");
   AST_HALT_HOLD:
      assert property (offchip_busy_o |-> !$past(offchip_halt))
      else $error("off-chip write while halted");
   AST_CORE_BLOCK:
      assert property (!offchip_halt |=> !core_xmem_grant_o)
      else $error("core granted off-chip RAM with halt 0");
   AST_BUSY_SPAN:
      assert property (offchip_busy_o |-> offchip_wr_o.we && !core_xmem_grant_o)
      else $error("busy flag without engine write");
   AST_PTR_STEP:
      assert property ((onchip_wr_o.we && !$past(wr_lo)) |->
         {write_ptr_high, write_ptr_low} == onchip_wr_o.addr + 16'h0001)
      else $error("write pointer did not step by one");
   AST_OVERFLOW:
      assert property ((conv_a_done_i && valid[0] && !take[0]) |=> stat[1])
      else $error("overflow not flagged");
   AST_RELEASE:
      assert property (!cfg_en |=> !conv_a_dma_own_o && !conv_b_dma_own_o)
      else $error("idle engine still owns a converter");
endmodule
`default_nettype wire

/* File: verilog/ardw_cfg.svh */
// Purpose: offsets, field positions and reset values of the result writer
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: included by bare name
`ifndef ARDW_CFG_SVH
`define ARDW_CFG_SVH
// register byte offsets
`define ARDW_OFS_CFG 8'h00
`define ARDW_OFS_INSTR_DATA 8'h04
`define ARDW_OFS_INSTR_IDX 8'h08
`define ARDW_OFS_PTR_LOW 8'h0c
`define ARDW_OFS_PTR_HIGH 8'h10
`define ARDW_OFS_STATUS 8'h14
`define ARDW_OFS_MASK 8'h18
// engine_config_reg fields
`define ARDW_CFG_EN 0
`define ARDW_CFG_OFFCHIP 1
`define ARDW_CFG_HALT 2
`define ARDW_CFG_BUSY 3
`define ARDW_CFG_CONT 4
// status and mask fields
`define ARDW_ST_DONE 0
`define ARDW_ST_OVF 1
// instruction list
`define ARDW_LIST_DEPTH 16
`define ARDW_LIST_AW 4
// reset values
`define ARDW_RST_PTR 16'h0000
`define ARDW_RST_HALT 1'h0
`define ARDW_RST_MASK 2'h0
`endif

/* File: verilog/ardw_pkg.sv */
// Purpose: types shared by the result writer
// Assumes: nothing beyond the cfg header
// Notes: none
`default_nettype none
package ardw_pkg;
   // one byte write toward a data RAM
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [7:0] data;
   } ardw_mem_wr_type;
   // decoded instruction word
   typedef struct packed {
      logic is_end;
      logic cont;
      logic use_a;
      logic use_b;
      logic diff;
   } ardw_instr_type;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_WAIT,
      ST_WRITE
   } ardw_state_type;
endpackage
`default_nettype wire

/* File: tb/ardw_far_model.sv */
// Purpose: far side of the result writer: two converters, two data RAMs
// Assumes: converters finish together every 16 cycles while run_i is high
// Notes: unwritten RAM bytes stay unknown, so stray writes show up
`timescale 1ns/10ps
`default_nettype none
module ardw_far_model #(
   parameter logic [15:0] A_VAL = 16'ha1a2,
   parameter logic [15:0] B_VAL = 16'hb1b2
) (
   // system
   input wire logic clk_i,
   input wire logic run_i,
   // converters
   output logic [15:0] conv_a_result_o,
   output logic [15:0] conv_b_result_o,
   output logic conv_done_o,
   // on-chip data RAM
   output logic core_ram_busy_o,
   input wire ardw_pkg::ardw_mem_wr_type onchip_wr_i,
   // off-chip data RAM
   input wire ardw_pkg::ardw_mem_wr_type offchip_wr_i,
   input wire logic offchip_busy_i
);
   logic [7:0] on_mem [0:65535];
   logic [7:0] off_mem [0:65535];
   logic [3:0] tick = 4'h0;
   logic busy_q = 1'b0;
   int on_n = 0;
   int viol = 0;
   int busy_n = 0;
   int bw_n = 0;
   int off_n = 0;
   // fixed results, high byte in the upper half
   assign conv_a_result_o = A_VAL;
   assign conv_b_result_o = B_VAL;
   assign conv_done_o = run_i && (tick == 4'h0);
   // core holds the on-chip RAM half of the time
   assign core_ram_busy_o = tick[1];
   always @(posedge clk_i) begin
      tick <= tick + 4'h1;
      busy_q <= core_ram_busy_o;
      if (onchip_wr_i.we) begin
         on_mem[onchip_wr_i.addr] <= onchip_wr_i.data;
         on_n <= on_n + 1;
         if (busy_q) begin
            viol <= viol + 1;
         end
      end
      if (offchip_wr_i.we) begin
         off_mem[offchip_wr_i.addr] <= offchip_wr_i.data;
         off_n <= off_n + 1;
      end
      if (offchip_busy_i) begin
         busy_n <= busy_n + 1;
      end
      if (offchip_busy_i && offchip_wr_i.we) begin
         bw_n <= bw_n + 1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/adc_result_dma_writer_tb.sv */
// Purpose: self-checking bench of the result writer
// Assumes: ardw_far_model supplies converters and both data RAMs
// Notes: classic Wishbone single cycles, no random stimulus
`timescale 1ns/10ps
`default_nettype none
`include "ardw_cfg.svh"
module adc_result_dma_writer_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat_w = 32'h0;
   logic run = 1'b0;
   ardw_pkg::ardw_mem_wr_type core_req = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic own_a, own_b, diff_mode, cont, grant, busy, irq_o, done, ram_busy;
   logic [15:0] res_a, res_b;
   ardw_pkg::ardw_mem_wr_type on_wr, off_wr;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int diff_n = 0;
   int d1 = 0;
   logic [7:0] list1 [6] = '{8'h90, 8'h20, 8'h30, 8'h50, 8'h70, 8'h80};
   logic [7:0] exp1 [14] = '{8'ha1, 8'ha2, 8'hb1, 8'hb2, 8'ha1, 8'ha2,
      8'hb1, 8'hb2, 8'ha1, 8'ha2, 8'ha1, 8'ha2, 8'hb1, 8'hb2};

   ardw_dma_writer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .conv_a_result_i(res_a), .conv_a_done_i(done),
      .conv_b_result_i(res_b), .conv_b_done_i(done),
      .conv_a_dma_own_o(own_a), .conv_b_dma_own_o(own_b),
      .diff_mode_o(diff_mode), .continuous_o(cont),
      .core_ram_busy_i(ram_busy), .onchip_wr_o(on_wr),
      .core_xmem_i(core_req), .offchip_wr_o(off_wr),
      .core_xmem_grant_o(grant), .offchip_busy_o(busy), .irq_o(irq_o));

   ardw_far_model u_far (.clk_i(clk_i), .run_i(run),
      .conv_a_result_o(res_a), .conv_b_result_o(res_b),
      .conv_done_o(done), .core_ram_busy_o(ram_busy),
      .onchip_wr_i(on_wr), .offchip_wr_i(off_wr), .offchip_busy_i(busy));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (diff_mode === 1'b1) begin
         diff_n <= diff_n + 1;
      end
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wb_cycle(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb_cycle(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_done;
      logic [31:0] q;
      q = 32'h0;
      while (q[0] !== 1'b1) begin
         rd(`ARDW_OFS_STATUS, q);
      end
   endtask

   task automatic core_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      core_req <= '{1'b1, a, d};
      @(posedge clk_i);
      core_req <= '0;
      repeat (3) @(posedge clk_i);
   endtask

   initial begin
      logic [31:0] q;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values and an unmapped place
      rd(`ARDW_OFS_PTR_LOW, q);
      check(q, 32'h0);
      rd(`ARDW_OFS_PTR_HIGH, q);
      check(q, 32'h0);
      rd(`ARDW_OFS_CFG, q);
      check(q, 32'h0);
      rd(8'hfc, q);
      check(q, 32'h0);
      $display("test reset done");
      // every data code, on-chip, pointer crossing a 256-byte boundary
      for (int i = 0; i < 6; i++) begin
         wr(`ARDW_OFS_INSTR_IDX, 32'(i));
         wr(`ARDW_OFS_INSTR_DATA, {24'h0, list1[i]});
      end
      wr(`ARDW_OFS_INSTR_IDX, 32'h3);
      rd(`ARDW_OFS_INSTR_DATA, q);
      check(q, 32'h50);
      wr(`ARDW_OFS_PTR_LOW, 32'hfe);
      wr(`ARDW_OFS_PTR_HIGH, 32'h12);
      wr(`ARDW_OFS_STATUS, 32'h3);
      wr(`ARDW_OFS_MASK, 32'h1);
      wr(`ARDW_OFS_CFG, 32'h1);
      run <= 1'b1;
      wait_done();
      run <= 1'b0;
      for (int i = 0; i < 14; i++) begin
         check({24'h0, u_far.on_mem[16'h12fe + i]}, {24'h0, exp1[i]});
      end
      check(32'(u_far.on_n), 32'he);
      check(32'(u_far.viol), 32'h0);
      rd(`ARDW_OFS_PTR_LOW, q);
      check(q, 32'h0c);
      rd(`ARDW_OFS_PTR_HIGH, q);
      check(q, 32'h13);
      rd(`ARDW_OFS_CFG, q);
      check(q & 32'h11, 32'h10);
      check({31'h0, cont}, 32'h1);
      check({31'h0, diff_n != 0}, 32'h1);
      d1 = diff_n;
      check({31'h0, irq_o}, 32'h1);
      wr(`ARDW_OFS_STATUS, 32'h3);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq_o}, 32'h0);
      $display("test on-chip list done");
      // off-chip, held by the core, results pile up
      wr(`ARDW_OFS_INSTR_IDX, 32'h0);
      wr(`ARDW_OFS_INSTR_DATA, 32'h20);
      wr(`ARDW_OFS_INSTR_IDX, 32'h1);
      wr(`ARDW_OFS_INSTR_DATA, 32'h00);
      wr(`ARDW_OFS_PTR_LOW, 32'h00);
      wr(`ARDW_OFS_PTR_HIGH, 32'h01);
      wr(`ARDW_OFS_MASK, 32'h0);
      rd(`ARDW_OFS_CFG, q);
      check(q & 32'h8, 32'h0);
      wr(`ARDW_OFS_CFG, 32'h6);
      wr(`ARDW_OFS_CFG, 32'h7);
      run <= 1'b1;
      repeat (80) @(posedge clk_i);
      rd(`ARDW_OFS_STATUS, q);
      check(q & 32'h2, 32'h2);
      check({30'h0, own_a, own_b}, 32'h1);
      check(32'(u_far.bw_n), 32'h0);
      core_wr(16'h0777, 8'h5a);
      check({24'h0, u_far.off_mem[16'h0777]}, 32'h5a);
      check({31'h0, grant}, 32'h1);
      wr(`ARDW_OFS_CFG, 32'h3);
      wait_done();
      run <= 1'b0;
      check({24'h0, u_far.off_mem[16'h0100]}, 32'hb1);
      check({24'h0, u_far.off_mem[16'h0101]}, 32'hb2);
      check(32'(u_far.busy_n), 32'h2);
      check(32'(u_far.bw_n), 32'h2);
      check({31'h0, cont}, 32'h0);
      check(32'(diff_n - d1), 32'h0);
      core_wr(16'h0778, 8'ha5);
      check({24'h0, u_far.off_mem[16'h0778]}, 32'h000000xx);
      check(32'(u_far.off_n), 32'h3);
      check({31'h0, irq_o}, 32'h0);
      wr(`ARDW_OFS_MASK, 32'h1);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq_o}, 32'h1);
      wr(`ARDW_OFS_STATUS, 32'h3);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq_o}, 32'h0);
      $display("test off-chip list done");
      wrap_up();
   end
endmodule
`default_nettype wire
